// file: inc/acs_pkg.sv
// Constants, register map and state type for the conversion sequencer.
// Assumes a 32-bit APB slave clocked by core_clk at 125 MHz.
package acs_pkg;
  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [11:0] OFF_CTRL0 = 12'h000;
  localparam logic [11:0] OFF_CTRL1 = 12'h004;
  localparam logic [11:0] OFF_CTRL2 = 12'h008;
  localparam logic [11:0] OFF_RES_HIGH = 12'h00c;
  localparam logic [11:0] OFF_RES_LOW = 12'h010;
  localparam logic [11:0] OFF_FLAGS = 12'h014;
  localparam logic [11:0] OFF_ENABLES = 12'h018;
  localparam logic [11:0] OFF_PRIORITY = 12'h01c;
  localparam logic [11:0] OFF_PORT_A = 12'h020;
  localparam logic [11:0] OFF_PORT_B = 12'h024;
  localparam logic [11:0] OFF_PORT_E = 12'h028;
  localparam logic [11:0] OFF_COMPARE2 = 12'h02c;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_ENABLE = 0;
  localparam int BIT_START = 1;
  localparam int POS_CHANNEL = 2;
  localparam int POS_CLK_SEL = 0;
  localparam int POS_ACQ = 3;
  localparam int BIT_FORMAT = 7;
  localparam int BIT_FLAG = 6;
  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [3:0] PCFG_ANALOG = 4'h0;
  localparam logic [3:0] PCFG_DIGITAL = 4'h7;
  localparam logic [3:0] CMP_TRIGGER_MODE = 4'hb;
  localparam logic [2:0] ACQ_MANUAL = 3'h0;
  localparam logic [4:0] CONV_BITS = 5'h0d;
  localparam logic [4:0] DISCHARGE_BITS = 5'h01;
  localparam logic [7:0] CYCLE_CLOCKS = 8'h04;
  localparam logic [7:0] WAIT_CYCLES = 8'h02;
  localparam int RC_TAD_NS = 2500;
  localparam int CLK_NS = 8;
  localparam logic [9:0] RC_TAD_CLOCKS = 10'(RC_TAD_NS / CLK_NS);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DELAY = 3'b001,
    ST_DISCH = 3'b010,
    ST_ACQ = 3'b011,
    ST_CONV = 3'b100,
    ST_WAIT = 3'b101
  } acs_state_type;
endpackage : acs_pkg

// file: src/acs_tick.sv
// Programmable tick divider that pulses once every period clocks.
// Assumes period is nonzero and held stable while running.
`timescale 1ns/1ps
module acs_tick (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Control
  input wire logic run,
  input wire logic [9:0] period,
  // Tick out
  output logic tick
);
  logic [9:0] count;
  assign tick = run && (count == period - 10'h001);
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || !run || tick)
      count <= 10'h000;
    else
      count <= count + 10'h001;
  end
endmodule : acs_tick

// file: src/acs_sar.sv
// Successive approximation register fed by a comparator decision.
// Assumes comp_high is valid whenever step is high.
`timescale 1ns/1ps
module acs_sar (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Control
  input wire logic clear,
  input wire logic step,
  input wire logic comp_high,
  // Trial and index
  output logic [11:0] trial,
  output logic [3:0] index
);
  logic [11:0] bit_mask;
  assign bit_mask = 12'h800 >> index;
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || clear)
    begin
      trial <= 12'h800;
      index <= 4'h0;
    end
    else if (step && index < 4'hc)
    begin
      trial <= (comp_high ? trial : (trial & ~bit_mask)) | (bit_mask >> 1);
      index <= index + 4'h1;
    end
  end
endmodule : acs_sar

// file: src/acs_top.sv
// Sequencer of a 12-bit successive approximation converter with APB registers.
// Assumes an external comparator answers comp_high for the current trial word.
// How it works
// - Clock select picks 2,4,8,16,32,64 oscillator periods or the internal RC clock.
// - Acquisition field zero delays conversion start one instruction cycle after start.
// - Port reads return zero on pins configured as analog inputs.
// - The selected channel converts regardless of direction; outputs convert their level.
// - A strap chooses whether port B analog config resets analog or digital.
// - Clearing start during conversion aborts it; result pair keeps old value.
// - After completion or abort wait two instruction cycles, then resume acquisition.
// - A discharge phase precedes every conversion.
// - Acquisition field 010 samples four bit times then converts.
// - Compare mode 1011 trigger with converter enabled sets the start bit.
// - Every special event trigger clears the associated timer counter.
// - With converter disabled the trigger is ignored but still clears the timer.
// - Each conversion takes thirteen conversion bit times.
// - Completion clears start, sets the complete flag and restarts sampling.
// - Nonzero acquisition field samples the programmed 2 to 20 bit times.
// - Acquisition field zero is manual and the reset value.
`timescale 1ns/1ps
module acs_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Straps and trigger
  input wire logic port_b_pins_analog_reset_select,
  input wire logic compare_event,
  // Analog front end
  input wire logic comp_high,
  input wire logic [7:0] pin_a_level,
  input wire logic [7:0] pin_b_level,
  input wire logic [3:0] pin_e_level,
  output logic [11:0] dac_trial,
  output logic [3:0] sample_channel,
  output logic sample_switch,
  output logic discharge,
  // Outputs to the rest of the chip
  output logic trigger_timer_clear,
  output logic irq_high,
  output logic irq_low
);
  // ****************************************
  // Registers
  // ****************************************
  logic converter_enable;
  logic go_bit;
  logic [3:0] channel_select;
  logic [3:0] pin_analog_config;
  logic ref_low_select;
  logic ref_high_select;
  logic [2:0] conv_clock_select;
  logic [2:0] acquisition_time_field;
  logic result_format;
  logic [11:0] result;
  logic conversion_complete_flag;
  logic conversion_complete_irq_enable;
  logic conversion_complete_priority;
  logic [3:0] compare2_mode_field;
  logic strap_done;
  acs_pkg::acs_state_type state;
  acs_pkg::acs_state_type next_state;
  logic [4:0] tad_count;
  logic [7:0] cyc_count;
  // ****************************************
  // APB decode
  // ****************************************
  wire setup_write = psel && !penable && pwrite;
  wire access_write = psel && penable && pwrite;
  wire access_read = psel && penable && !pwrite;
  wire sel_ctrl0 = paddr == acs_pkg::OFF_CTRL0;
  wire sel_ctrl1 = paddr == acs_pkg::OFF_CTRL1;
  wire sel_ctrl2 = paddr == acs_pkg::OFF_CTRL2;
  wire sel_res_high = paddr == acs_pkg::OFF_RES_HIGH;
  wire sel_res_low = paddr == acs_pkg::OFF_RES_LOW;
  wire sel_flags = paddr == acs_pkg::OFF_FLAGS;
  wire sel_enables = paddr == acs_pkg::OFF_ENABLES;
  wire sel_priority = paddr == acs_pkg::OFF_PRIORITY;
  wire sel_port_a = paddr == acs_pkg::OFF_PORT_A;
  wire sel_port_b = paddr == acs_pkg::OFF_PORT_B;
  wire sel_port_e = paddr == acs_pkg::OFF_PORT_E;
  wire sel_cmp2 = paddr == acs_pkg::OFF_COMPARE2;
  wire mapped = sel_ctrl0 | sel_ctrl1 | sel_ctrl2 | sel_res_high | sel_res_low | sel_flags
    | sel_enables | sel_priority | sel_port_a | sel_port_b | sel_port_e | sel_cmp2;
  wire wr_ctrl0 = access_write && sel_ctrl0;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  // ****************************************
  // Timing
  // ****************************************
  wire use_rc = conv_clock_select[1:0] == 2'b11;
  wire [2:0] div_code = {conv_clock_select[1:0], conv_clock_select[2]};
  wire [9:0] tad_period = use_rc ? acs_pkg::RC_TAD_CLOCKS
    : (10'h002 << div_code);
  wire [4:0] acq_bits;
  wire running = state != acs_pkg::ST_IDLE && state != acs_pkg::ST_DELAY
    && state != acs_pkg::ST_WAIT;
  wire tad_tick;
  acs_tick u_tick (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .run(running),
    .period(tad_period),
    .tick(tad_tick)
  );
  // Acquisition lengths in bit times for each field code.
  assign acq_bits = (acquisition_time_field == 3'h1) ? 5'h02 :
    (acquisition_time_field == 3'h2) ? 5'h04 :
    (acquisition_time_field == 3'h3) ? 5'h06 :
    (acquisition_time_field == 3'h4) ? 5'h08 :
    (acquisition_time_field == 3'h5) ? 5'h0c :
    (acquisition_time_field == 3'h6) ? 5'h10 :
    (acquisition_time_field == 3'h7) ? 5'h14 : 5'h00;
  // ****************************************
  // Trigger and start
  // ****************************************
  wire trig_valid = compare_event && compare2_mode_field == acs_pkg::CMP_TRIGGER_MODE;
  wire trig_start = trig_valid && converter_enable;
  assign trigger_timer_clear = trig_valid;
  wire sw_go_set = wr_ctrl0 && pwdata[acs_pkg::BIT_START] && converter_enable;
  wire sw_go_clr = wr_ctrl0 && !pwdata[acs_pkg::BIT_START];
  wire go_rise = !go_bit && (sw_go_set || trig_start);
  wire abort = go_bit && (sw_go_clr || !converter_enable) && (state == acs_pkg::ST_CONV
    || state == acs_pkg::ST_DISCH || state == acs_pkg::ST_ACQ || state == acs_pkg::ST_DELAY);
  // An abort in the last bit time wins, so the result pair is not updated.
  wire conv_done = state == acs_pkg::ST_CONV && tad_tick
    && tad_count == acs_pkg::CONV_BITS - 5'h01 && !abort;
  // ****************************************
  // Sequencer
  // ****************************************
  always_comb
  begin
    next_state = state;
    case (state)
      acs_pkg::ST_IDLE:
        // A start set during the post-conversion wait is held and taken here.
        if (go_rise || go_bit)
          next_state = (acquisition_time_field == acs_pkg::ACQ_MANUAL) ? acs_pkg::ST_DELAY
            : acs_pkg::ST_ACQ;
      acs_pkg::ST_DELAY:
        if (cyc_count == acs_pkg::CYCLE_CLOCKS - 8'h01)
          next_state = acs_pkg::ST_DISCH;
      acs_pkg::ST_ACQ:
        if (tad_tick && tad_count == acq_bits - 5'h01)
          next_state = acs_pkg::ST_DISCH;
      acs_pkg::ST_DISCH:
        if (tad_tick)
          next_state = acs_pkg::ST_CONV;
      acs_pkg::ST_CONV:
        if (conv_done)
          next_state = acs_pkg::ST_WAIT;
      acs_pkg::ST_WAIT:
        if (cyc_count == acs_pkg::WAIT_CYCLES * acs_pkg::CYCLE_CLOCKS - 8'h01)
          next_state = acs_pkg::ST_IDLE;
      default:
        next_state = acs_pkg::ST_IDLE;
    endcase
    if (abort)
      next_state = acs_pkg::ST_WAIT;
  end
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      state <= acs_pkg::ST_IDLE;
    else
      state <= next_state;
  end
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || next_state != state)
      tad_count <= 5'h00;
    else if (tad_tick)
      tad_count <= tad_count + 5'h01;
  end
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || next_state != state)
      cyc_count <= 8'h00;
    else
      cyc_count <= cyc_count + 8'h01;
  end
  wire sar_step = state == acs_pkg::ST_CONV && tad_tick && tad_count != 5'h00;
  logic [3:0] sar_index;
  acs_sar u_sar (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clear(state != acs_pkg::ST_CONV),
    .step(sar_step),
    .comp_high(comp_high),
    .trial(dac_trial),
    .index(sar_index)
  );
  // Sampling runs while the converter is on and the sequencer is idle or acquiring.
  assign sample_switch = converter_enable && (state == acs_pkg::ST_IDLE
    || state == acs_pkg::ST_ACQ);
  assign discharge = state == acs_pkg::ST_DISCH;
  assign sample_channel = channel_select;
  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      converter_enable <= 1'b0;
      channel_select <= 4'h0;
      go_bit <= 1'b0;
    end
    else
    begin
      if (wr_ctrl0)
      begin
        converter_enable <= pwdata[acs_pkg::BIT_ENABLE];
        channel_select <= pwdata[acs_pkg::POS_CHANNEL +: 4];
      end
      if (go_rise)
        go_bit <= 1'b1;
      else if (conv_done || abort || sw_go_clr)
        go_bit <= 1'b0;
    end
  end
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      conv_clock_select <= 3'h0;
      acquisition_time_field <= acs_pkg::ACQ_MANUAL;
      result_format <= 1'b0;
      ref_low_select <= 1'b0;
      ref_high_select <= 1'b0;
      compare2_mode_field <= 4'h0;
      conversion_complete_irq_enable <= 1'b0;
      conversion_complete_priority <= 1'b1;
    end
    else
    begin
      if (access_write && sel_ctrl2)
      begin
        conv_clock_select <= pwdata[acs_pkg::POS_CLK_SEL +: 3];
        acquisition_time_field <= pwdata[acs_pkg::POS_ACQ +: 3];
        result_format <= pwdata[acs_pkg::BIT_FORMAT];
      end
      if (access_write && sel_ctrl1)
      begin
        ref_low_select <= pwdata[5];
        ref_high_select <= pwdata[4];
      end
      if (access_write && sel_cmp2)
        compare2_mode_field <= pwdata[3:0];
      if (access_write && sel_enables)
        conversion_complete_irq_enable <= pwdata[acs_pkg::BIT_FLAG];
      if (access_write && sel_priority)
        conversion_complete_priority <= pwdata[acs_pkg::BIT_FLAG];
    end
  end
  // The pin configuration reset value follows the strap sampled after release.
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      pin_analog_config <= acs_pkg::PCFG_DIGITAL;
      strap_done <= 1'b0;
    end
    else if (!strap_done)
    begin
      pin_analog_config <= port_b_pins_analog_reset_select ? acs_pkg::PCFG_ANALOG
        : acs_pkg::PCFG_DIGITAL;
      strap_done <= 1'b1;
    end
    else if (access_write && sel_ctrl1)
      pin_analog_config <= pwdata[3:0];
  end
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      conversion_complete_flag <= 1'b0;
    else if (conv_done)
      conversion_complete_flag <= 1'b1;
    else if (access_write && sel_flags)
      conversion_complete_flag <= pwdata[acs_pkg::BIT_FLAG];
  end
  wire [11:0] final_word = comp_high ? dac_trial : (dac_trial & 12'hffe);
  wire [15:0] res_just = result_format ? {4'h0, result} : {result, 4'h0};
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      result <= 12'h000;
    else if (conv_done)
      result <= final_word;
    else if (access_write && sel_res_high)
      result <= result_format ? {pwdata[3:0], result[7:0]} : {pwdata[7:0], result[3:0]};
    else if (access_write && sel_res_low)
      result <= result_format ? {result[11:8], pwdata[7:0]} : {result[11:4], pwdata[7:4]};
  end
  assign irq_high = conversion_complete_flag && conversion_complete_irq_enable
    && conversion_complete_priority;
  assign irq_low = conversion_complete_flag && conversion_complete_irq_enable
    && !conversion_complete_priority;
  // ****************************************
  // Read mux
  // ****************************************
  // Channels 0-4 on port A, 5-7 on port E, 8-12 on port B; lower codes mean more analog.
  wire [12:0] analog_mask;
  genvar gi;
  generate
    for (gi = 0; gi < 13; gi++)
    begin : g_mask
      assign analog_mask[gi] = 4'(gi) < (4'hf - pin_analog_config);
    end
  endgenerate
  wire [7:0] port_a_view = pin_a_level & ~{2'b00, 1'b0, analog_mask[4:0]};
  wire [7:0] port_b_view = pin_b_level & ~{3'b000, analog_mask[12:8]};
  wire [3:0] port_e_view = pin_e_level & ~{1'b0, analog_mask[7:5]};
  wire [7:0] rd_mux = sel_ctrl0 ? {2'b00, channel_select, go_bit, converter_enable} :
    sel_ctrl1 ? {2'b00, ref_low_select, ref_high_select, pin_analog_config} :
    sel_ctrl2 ? {result_format, 1'b0, acquisition_time_field, conv_clock_select} :
    sel_res_high ? res_just[15:8] :
    sel_res_low ? res_just[7:0] :
    sel_flags ? {1'b0, conversion_complete_flag, 6'h00} :
    sel_enables ? {1'b0, conversion_complete_irq_enable, 6'h00} :
    sel_priority ? {1'b0, conversion_complete_priority, 6'h00} :
    sel_port_a ? port_a_view :
    sel_port_b ? port_b_view :
    sel_port_e ? {4'h0, port_e_view} :
    sel_cmp2 ? {4'h0, compare2_mode_field} : 8'h00;
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= {24'h00_0000, rd_mux};
  end
  // ****************************************
  // Assertions
  // ****************************************
  property p_done_flag;
    @(posedge core_clk) disable iff (!rst_b) conv_done |=> conversion_complete_flag && !go_bit;
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("done did not set flag");
  property p_wait_len;
    @(posedge core_clk) disable iff (!rst_b)
      $rose(state == acs_pkg::ST_WAIT) |-> (state == acs_pkg::ST_WAIT)[*8] ##1
      state == acs_pkg::ST_IDLE;
  endproperty
  a_wait_len: assert property (p_wait_len) else $error("post wait wrong length");
  property p_trig_clear;
    @(posedge core_clk) disable iff (!rst_b)
      compare_event && compare2_mode_field == 4'hb |-> trigger_timer_clear;
  endproperty
  a_trig_clear: assert property (p_trig_clear) else $error("trigger did not clear timer");
  property p_trig_ignored;
    @(posedge core_clk) disable iff (!rst_b)
      !converter_enable && !go_bit |=> !go_bit;
  endproperty
  a_trig_ignored: assert property (p_trig_ignored) else $error("start set while off");
  property p_abort_keep;
    @(posedge core_clk) disable iff (!rst_b)
      abort && !(access_write && (sel_res_high || sel_res_low)) |=> $stable(result);
  endproperty
  a_abort_keep: assert property (p_abort_keep) else $error("abort changed result");
  property p_manual_delay;
    @(posedge core_clk) disable iff (!rst_b)
      state == acs_pkg::ST_IDLE && go_rise && acquisition_time_field == 3'h0 && !abort
      |=> state == acs_pkg::ST_DELAY;
  endproperty
  a_manual_delay: assert property (p_manual_delay) else $error("no start delay");
  property p_disch_before;
    @(posedge core_clk) disable iff (!rst_b)
      $rose(state == acs_pkg::ST_CONV) |-> $past(state) == acs_pkg::ST_DISCH;
  endproperty
  a_disch_before: assert property (p_disch_before) else $error("no discharge");
  property p_conv_len;
    @(posedge core_clk) disable iff (!rst_b)
      conv_done |-> tad_count == 5'h0c && sar_index == 4'hb;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion not 13 bits");
  property p_irq;
    @(posedge core_clk) disable iff (!rst_b)
      conversion_complete_flag && conversion_complete_irq_enable
      |-> irq_high != irq_low && irq_high == conversion_complete_priority;
  endproperty
  a_irq: assert property (p_irq) else $error("enabled flag gave no request");
endmodule : acs_top

// file: verification/acs_analog_src.sv
// Analog source model: one voltage on the selected channel and digital pin levels.
// Assumes the sequencer compares its trial word against the held input.
`timescale 1ns/1ps
module acs_analog_src (
  // Sequencer side
  input wire logic [11:0] dac_trial,
  input wire logic [3:0] sample_channel,
  // Source setting from the bench
  input wire logic [11:0] source_level,
  // Comparator and pins
  output logic comp_high,
  output logic [7:0] pin_a_level,
  output logic [7:0] pin_b_level,
  output logic [3:0] pin_e_level
);
  // ****************************************
  // Comparator
  // ****************************************
  // Every channel carries the same level, so the answer holds whatever the selection.
  assign comp_high = (source_level >= dac_trial);
  assign pin_a_level = 8'hff;
  assign pin_b_level = 8'hff;
  assign pin_e_level = 4'hf;
endmodule : acs_analog_src

// file: verification/tb_acs_top.sv
// Self-checking bench of the conversion sequencer over APB.
// Assumes a zero wait APB slave and the analog source model.
`timescale 1ns/1ps
module tb_acs_top;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, comp_high, compare_event = 1'b0, last_err;
  logic [7:0] pin_a_level, pin_b_level;
  logic [3:0] pin_e_level, sample_channel;
  logic [11:0] dac_trial, source_level = 12'h5a3;
  logic trigger_timer_clear, irq_high, irq_low;
  logic strap = 1'b0, sample_switch;
  logic [31:0] q;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  always #4 core_clk = ~core_clk;
  acs_top uut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_b_pins_analog_reset_select(strap), .compare_event(compare_event),
    .comp_high(comp_high), .pin_a_level(pin_a_level), .pin_b_level(pin_b_level),
    .pin_e_level(pin_e_level), .dac_trial(dac_trial), .sample_channel(sample_channel),
    .sample_switch(sample_switch), .discharge(), .trigger_timer_clear(trigger_timer_clear),
    .irq_high(irq_high), .irq_low(irq_low));
  acs_analog_src src (.dac_trial(dac_trial), .sample_channel(sample_channel),
    .source_level(source_level), .comp_high(comp_high), .pin_a_level(pin_a_level),
    .pin_b_level(pin_b_level), .pin_e_level(pin_e_level));
  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic rd(input logic [11:0] a, input string what, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, q, exp);
  endtask : rd
  task automatic wait_done();
    int n;
    n = 0;
    q = 32'h0000_0002;
    while (q[1] !== 1'b0 && n < 400)
    begin
      apb(1'b0, acs_pkg::OFF_CTRL0, 32'h0000_0000);
      n++;
    end
    chk("start cleared", {31'h0, q[1]}, 32'h0000_0000);
  endtask : wait_done
  task automatic pulse_event(input logic exp_clear);
    @(posedge core_clk);
    compare_event <= 1'b1;
    @(negedge core_clk);
    chk("timer clear", {31'h0, trigger_timer_clear}, {31'h0, exp_clear});
    @(posedge core_clk);
    compare_event <= 1'b0;
  endtask : pulse_event
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      bad_count++;
      summarize();
    end
  end
  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(acs_pkg::OFF_CTRL1, "strap pcfg", 32'h0000_0007);
    rd(acs_pkg::OFF_CTRL2, "acq reset", 32'h0000_0000);
    rd(acs_pkg::OFF_PRIORITY, "priority reset", 32'h0000_0040);
    apb(1'b1, acs_pkg::OFF_CTRL1, 32'h0000_000f);
    rd(acs_pkg::OFF_PORT_A, "digital port", 32'h0000_00ff);
    apb(1'b1, acs_pkg::OFF_CTRL1, 32'h0000_0000);
    apb(1'b0, acs_pkg::OFF_PORT_A, 32'h0000_0000);
    chk("analog pin", {31'h0, q[0]}, 32'h0000_0000);
    rd(12'hff0, "unmapped data", 32'h0000_0000);
    chk("unmapped err", {31'h0, last_err}, 32'h0000_0001);
    $display("test registers done");
    apb(1'b1, acs_pkg::OFF_CTRL2, 32'h0000_0080);
    apb(1'b1, acs_pkg::OFF_CTRL0, 32'h0000_0001);
    repeat (8) @(posedge core_clk);
    apb(1'b1, acs_pkg::OFF_ENABLES, 32'h0000_0040);
    apb(1'b1, acs_pkg::OFF_CTRL0, 32'h0000_0003);
    wait_done();
    rd(acs_pkg::OFF_RES_HIGH, "right high", 32'h0000_0005);
    rd(acs_pkg::OFF_RES_LOW, "right low", 32'h0000_00a3);
    rd(acs_pkg::OFF_FLAGS, "flag set", 32'h0000_0040);
    @(negedge core_clk);
    chk("irq high", {30'h0, irq_high, irq_low}, 32'h0000_0002);
    chk("sampling resumes", {31'h0, sample_switch}, 32'h0000_0001);
    apb(1'b1, acs_pkg::OFF_FLAGS, 32'h0000_0000);
    @(negedge core_clk);
    chk("irq cleared", {30'h0, irq_high, irq_low}, 32'h0000_0000);
    $display("test manual done");
    apb(1'b1, acs_pkg::OFF_CTRL2, 32'h0000_0010);
    apb(1'b1, acs_pkg::OFF_CTRL0, 32'h0000_0003);
    wait_done();
    rd(acs_pkg::OFF_RES_HIGH, "left high", 32'h0000_005a);
    rd(acs_pkg::OFF_RES_LOW, "left low", 32'h0000_0030);
    $display("test timed done");
    source_level <= 12'h123;
    apb(1'b1, acs_pkg::OFF_CTRL2, 32'h0000_0006);
    apb(1'b1, acs_pkg::OFF_CTRL0, 32'h0000_0003);
    repeat (200) @(posedge core_clk);
    apb(1'b1, acs_pkg::OFF_CTRL0, 32'h0000_0001);
    repeat (1200) @(posedge core_clk);
    rd(acs_pkg::OFF_RES_HIGH, "abort keeps", 32'h0000_005a);
    $display("test abort done");
    apb(1'b1, acs_pkg::OFF_CTRL2, 32'h0000_0008);
    apb(1'b1, acs_pkg::OFF_COMPARE2, 32'h0000_000b);
    apb(1'b1, acs_pkg::OFF_CTRL0, 32'h0000_0000);
    pulse_event(1'b1);
    rd(acs_pkg::OFF_CTRL0, "disabled ignores", 32'h0000_0000);
    apb(1'b1, acs_pkg::OFF_CTRL0, 32'h0000_0001);
    repeat (8) @(posedge core_clk);
    pulse_event(1'b1);
    rd(acs_pkg::OFF_CTRL0, "trigger starts", 32'h0000_0003);
    wait_done();
    rd(acs_pkg::OFF_RES_HIGH, "trigger result", 32'h0000_0012);
    $display("test trigger done");
    source_level <= 12'h7c4;
    apb(1'b1, acs_pkg::OFF_CTRL2, 32'h0000_0003);
    apb(1'b1, acs_pkg::OFF_CTRL0, 32'h0000_0003);
    repeat (4300) @(posedge core_clk);
    rd(acs_pkg::OFF_CTRL0, "rc still busy", 32'h0000_0003);
    wait_done();
    rd(acs_pkg::OFF_RES_HIGH, "rc result", 32'h0000_007c);
    $display("test rc clock done");
    strap <= 1'b1;
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(acs_pkg::OFF_CTRL1, "strap analog", 32'h0000_0000);
    rd(acs_pkg::OFF_CTRL2, "acq reset again", 32'h0000_0000);
    $display("test reset done");
    summarize();
  end
endmodule : tb_acs_top
